//--- verilog/uart_shadow_pkg.sv
// Constants for the serial port queue control aliases
// Overview of operation
// - Queue enable alias bit 0 mirrors control bit 0
// - Enable alias write leaves other control fields
// - Enable one uses queues, zero disables them
// - Enable falling resets both queue controllers
// - Threshold alias bits 1:0 mirror control 7:6
// - Threshold alias write leaves other control fields
// - Receive fill reaching threshold raises data interrupt
// - DMA mode one: threshold drives receive request
// - Threshold codes: one, quarter, half, full minus two
// - DMA mode bit selects mode 0 or 1
// - Flow control gates request-to-send by threshold
package uart_shadow_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADR_DATA = 32'h5000_1000;
  localparam logic [31:0] ADR_FCR = 32'h5000_1008;
  localparam logic [31:0] ADR_CTRL = 32'h5000_100c;
  localparam logic [31:0] ADR_IRQ_STATUS = 32'h5000_1010;
  localparam logic [31:0] ADR_IRQ_MASK = 32'h5000_1014;
  localparam logic [31:0] ADR_LEVELS = 32'h5000_1018;
  localparam logic [31:0] ADR_QUEUE_ENABLE_ALIAS = 32'h5000_1098;
  localparam logic [31:0] ADR_RX_THRESHOLD_ALIAS = 32'h5000_109c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_RX_CLR_BIT = 1;
  localparam int FCR_TX_CLR_BIT = 2;
  localparam int FCR_DMA_BIT = 3;
  localparam int FCR_TX_TRIG_LSB = 4;
  localparam int FCR_RX_TRIG_LSB = 6;
  localparam logic [7:0] FCR_RESET = 8'h00;
  localparam int CTRL_RTS_BIT = 0;
  localparam int CTRL_AFC_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int IRQ_RX_AVAIL = 0;
  localparam int IRQ_TX_EMPTY = 1;
  localparam int IRQ_OVERRUN = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam int LEVEL_TX_LSB = 8;

  // ----------------------------------------------------------------
  // Threshold codes and sizes
  // ----------------------------------------------------------------
  localparam logic [1:0] RX_TRIG_ONE = 2'h0;
  localparam logic [1:0] RX_TRIG_QUARTER = 2'h1;
  localparam logic [1:0] RX_TRIG_HALF = 2'h2;
  localparam logic [1:0] TX_TRIG_EMPTY = 2'h0;
  localparam logic [1:0] TX_TRIG_TWO = 2'h1;
  localparam logic [1:0] TX_TRIG_QUARTER = 2'h2;
  localparam int QUEUE_DEPTH = 16;
  localparam int CHAR_W = 8;
  localparam int ACK_LATENCY = 2;

endpackage : uart_shadow_pkg

//--- verilog/uart_queue_ram.sv
// Small two-port queue memory with registered read data
`timescale 1ns/1ns
module uart_queue_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Old data on a same-address collision; callers never read a fresh slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule : uart_queue_ram

//--- verilog/uart_fifo_shadow_controls.sv
// Serial port queues with control aliases behind a Wishbone slave
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ns
module uart_fifo_shadow_controls
  import uart_shadow_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int AW = $clog2(DEPTH),
  parameter int CW = AW + 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_o,
  input wire logic [CHAR_W-1:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic [CHAR_W-1:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic rx_dma_req_n_o,
  output logic tx_dma_req_n_o,
  output logic rts_n_o
);

  // ----------------------------------------------------------------
  // Threshold decoding
  // ----------------------------------------------------------------
  function automatic logic [CW-1:0] rx_trig_level(input logic [1:0] code);
    logic [CW-1:0] lvl;
    lvl = CW'(DEPTH - 2);
    // Threshold decode
    case (code)
      RX_TRIG_ONE: lvl = CW'(1);
      RX_TRIG_QUARTER: lvl = CW'(DEPTH / 4);
      RX_TRIG_HALF: lvl = CW'(DEPTH / 2);
      default: lvl = CW'(DEPTH - 2);
    endcase
    return lvl;
  endfunction : rx_trig_level

  function automatic logic [CW-1:0] tx_trig_level(input logic [1:0] code);
    logic [CW-1:0] lvl;
    lvl = CW'(DEPTH / 2);
    case (code)
      TX_TRIG_EMPTY: lvl = CW'(0);
      TX_TRIG_TWO: lvl = CW'(2);
      TX_TRIG_QUARTER: lvl = CW'(DEPTH / 4);
      default: lvl = CW'(DEPTH / 2);
    endcase
    return lvl;
  endfunction : tx_trig_level

  typedef enum logic {TX_IDLE, TX_FETCH} tx_state_t;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] fifo_control_register;
  logic [1:0] ctrl;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic req_seen;
  logic rx_empty_q;
  logic [AW-1:0] rx_wr_ptr;
  logic [AW-1:0] rx_rd_ptr;
  logic [CW-1:0] rx_count;
  logic [AW-1:0] tx_wr_ptr;
  logic [AW-1:0] tx_rd_ptr;
  logic [CW-1:0] tx_count;
  logic rx_dma_act;
  logic tx_dma_act;
  tx_state_t tx_state;
  logic [CHAR_W-1:0] rx_rdata;
  logic [CHAR_W-1:0] tx_rdata;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire req = cyc_i & stb_i & ~req_seen & ~ack_o;
  wire wr_en = req_seen & we_i & sel_i[0];
  wire rd_en = req_seen & ~we_i;
  wire hit_data = adr_i == ADR_DATA;
  wire hit_fcr = adr_i == ADR_FCR;
  wire hit_ctrl = adr_i == ADR_CTRL;
  wire hit_status = adr_i == ADR_IRQ_STATUS;
  wire hit_mask = adr_i == ADR_IRQ_MASK;
  wire hit_levels = adr_i == ADR_LEVELS;
  wire hit_sfe = adr_i == ADR_QUEUE_ENABLE_ALIAS;
  wire hit_srt = adr_i == ADR_RX_THRESHOLD_ALIAS;
  wire wr_fcr = wr_en & hit_fcr;
  wire wr_sfe = wr_en & hit_sfe;
  wire wr_srt = wr_en & hit_srt;

  // ----------------------------------------------------------------
  // Control register and aliases
  // ----------------------------------------------------------------
  // Clear bits never stored, so alias writes cannot replay them
  wire [7:0] fcr_written = {dat_i[7:3], 2'h0, dat_i[0]};
  // enable alias touches bit 0 only
  wire [7:0] fcr_sfe = {fifo_control_register[7:1], dat_i[0]};
  // threshold alias touches bits 7:6 only
  wire [7:0] fcr_srt = {dat_i[1:0], fifo_control_register[5:0]};
  wire [7:0] next_fcr = wr_fcr ? fcr_written : wr_sfe ? fcr_sfe : wr_srt ? fcr_srt : fifo_control_register;
  wire q_enable = fifo_control_register[FCR_EN_BIT];
  wire dma_mode = fifo_control_register[FCR_DMA_BIT];
  wire en_fall = q_enable & ~next_fcr[FCR_EN_BIT];
  wire rx_clr = en_fall | (wr_fcr & dat_i[FCR_RX_CLR_BIT]);
  wire tx_clr = en_fall | (wr_fcr & dat_i[FCR_TX_CLR_BIT]);
  // disabled queues hold a single character
  wire [CW-1:0] cap = q_enable ? CW'(DEPTH) : CW'(1);
  wire [CW-1:0] rx_level = q_enable ? rx_trig_level(fifo_control_register[7:6]) : CW'(1);
  wire [CW-1:0] tx_level = q_enable ? tx_trig_level(fifo_control_register[5:4]) : CW'(0);

  // ----------------------------------------------------------------
  // Receive queue
  // ----------------------------------------------------------------
  wire rx_full = rx_count >= cap;
  wire rx_push = rx_valid_i & ~rx_full & ~rx_clr;
  wire rx_overrun = rx_valid_i & rx_full;
  wire rx_pop = rd_en & hit_data & ~rx_empty_q & ~rx_clr;
  wire [CW-1:0] next_rx_count = rx_clr ? '0 : rx_count + CW'(rx_push) - CW'(rx_pop);
  wire rx_at_level = rx_count >= rx_level;

  uart_queue_ram #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) rx_ram (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(rx_push),
    .wr_addr_i(rx_wr_ptr),
    .wr_data_i(rx_data_i),
    .rd_addr_i(rx_rd_ptr),
    .rd_data_o(rx_rdata)
  );

  // ----------------------------------------------------------------
  // Transmit queue
  // ----------------------------------------------------------------
  wire tx_push = wr_en & hit_data & (tx_count < cap) & ~tx_clr;
  wire tx_pop = (tx_state == TX_FETCH) & ~tx_clr;
  wire [CW-1:0] next_tx_count = tx_clr ? '0 : tx_count + CW'(tx_push) - CW'(tx_pop);
  wire next_tx_valid = tx_clr ? 1'b0 : tx_pop ? 1'b1 : (tx_valid_o & ~tx_ready_i);
  // Fetch takes a cycle: read data is registered inside the memory
  wire tx_start = (tx_state == TX_IDLE) & (tx_count != '0) & ~tx_valid_o & ~tx_clr;

  uart_queue_ram #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) tx_ram (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(tx_push),
    .wr_addr_i(tx_wr_ptr),
    .wr_data_i(dat_i[CHAR_W-1:0]),
    .rd_addr_i(tx_rd_ptr),
    .rd_data_o(tx_rdata)
  );

  // ----------------------------------------------------------------
  // Interrupts, DMA requests, flow control
  // ----------------------------------------------------------------
  // fill at threshold raises data event
  wire [IRQ_W-1:0] irq_set = {rx_overrun, tx_count == '0, rx_at_level};
  wire [IRQ_W-1:0] irq_clr = (wr_en & hit_status) ? dat_i[IRQ_W-1:0] : '0;
  // Set wins over a write-one clear in the same cycle
  wire [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_set;
  // mode 1 asserts at threshold, holds until empty
  wire next_rx_dma_act = rx_at_level | (rx_dma_act & (rx_count != '0));
  wire next_tx_dma_act = (tx_count <= tx_level) | (tx_dma_act & (tx_count < cap));
  wire rx_req = dma_mode ? next_rx_dma_act : (rx_count != '0);
  wire tx_req = dma_mode ? next_tx_dma_act : (tx_count == '0);
  // flow control drops request-to-send at threshold
  wire afc_on = ctrl[CTRL_AFC_BIT] & q_enable;
  wire next_rts_n = ~(ctrl[CTRL_RTS_BIT] & ~(afc_on & rx_at_level));

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [CW-1:0] rx_level_cnt = rx_count;
  wire [31:0] rd_levels = {16'h0000, CHAR_W'(tx_count), CHAR_W'(rx_level_cnt)};
  wire [31:0] rd_sfe = {31'h0000_0000, fifo_control_register[FCR_EN_BIT]};
  wire [31:0] rd_srt = {30'h0000_0000, fifo_control_register[FCR_RX_TRIG_LSB+1:FCR_RX_TRIG_LSB]};
  wire [31:0] rd_data = rx_empty_q ? 32'h0000_0000 : {24'h00_0000, rx_rdata};
  // Control register is write-only, so it reads as zero
  wire [31:0] rd_mux = hit_data ? rd_data :
                       hit_ctrl ? {30'h0000_0000, ctrl} :
                       hit_status ? {29'h0000_0000, irq_status} :
                       hit_mask ? {29'h0000_0000, irq_mask} :
                       hit_levels ? rd_levels :
                       hit_sfe ? rd_sfe :
                       hit_srt ? rd_srt : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_seen <= 1'b0;
      ack_o <= 1'b0;
      rx_empty_q <= 1'b1;
      dat_o <= '0;
    end else begin
      req_seen <= req;
      ack_o <= req_seen;
      rx_empty_q <= req ? (rx_count == '0) : rx_empty_q;
      dat_o <= rd_en ? rd_mux : '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_control_register <= FCR_RESET;
      ctrl <= CTRL_RESET;
      irq_status <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
    end else begin
      fifo_control_register <= next_fcr;
      ctrl <= (wr_en & hit_ctrl) ? dat_i[1:0] : ctrl;
      irq_status <= next_irq_status;
      irq_mask <= (wr_en & hit_mask) ? dat_i[IRQ_W-1:0] : irq_mask;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_clr) begin
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
    end else begin
      rx_wr_ptr <= rx_wr_ptr + AW'(rx_push);
      rx_rd_ptr <= rx_rd_ptr + AW'(rx_pop);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || tx_clr) begin
      tx_wr_ptr <= '0;
      tx_rd_ptr <= '0;
    end else begin
      tx_wr_ptr <= tx_wr_ptr + AW'(tx_push);
      tx_rd_ptr <= tx_rd_ptr + AW'(tx_pop);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_count <= '0;
      tx_count <= '0;
      tx_state <= TX_IDLE;
      tx_valid_o <= 1'b0;
      tx_data_o <= '0;
    end else begin
      rx_count <= next_rx_count;
      tx_count <= next_tx_count;
      case (tx_state)
        TX_IDLE: tx_state <= tx_start ? TX_FETCH : TX_IDLE;
        TX_FETCH: tx_state <= TX_IDLE;
        default: tx_state <= TX_IDLE;
      endcase
      tx_valid_o <= next_tx_valid;
      tx_data_o <= tx_pop ? tx_rdata : tx_data_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_dma_act <= 1'b0;
      tx_dma_act <= 1'b0;
      rx_dma_req_n_o <= 1'b1;
      tx_dma_req_n_o <= 1'b1;
      rts_n_o <= 1'b1;
      irq_o <= 1'b0;
    end else begin
      rx_dma_act <= next_rx_dma_act;
      tx_dma_act <= next_tx_dma_act;
      rx_dma_req_n_o <= ~rx_req;
      tx_dma_req_n_o <= ~tx_req;
      rts_n_o <= next_rts_n;
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence alias_read_s;
    req && !we_i && (hit_sfe || hit_srt);
  endsequence

  sequence answer_zero_top_s;
    ##2 (ack_o && dat_o[31:2] == 30'h0000_0000);
  endsequence

  sfe_store_a: assert property (wr_sfe |=> fifo_control_register[0] == $past(dat_i[0]))
    else $error("enable alias write not stored");
  sfe_keep_a: assert property (wr_sfe |=> fifo_control_register[7:1] == $past(fifo_control_register[7:1]))
    else $error("enable alias write disturbed other fields");
  disabled_cap_a: assert property (!q_enable |-> rx_count <= CW'(1))
    else $error("disabled queue held more than one character");
  disable_reset_a: assert property ($fell(q_enable) |-> rx_count == '0 && tx_count == '0)
    else $error("queues not reset when disabled");
  srt_store_a: assert property (wr_srt |=> fifo_control_register == {$past(dat_i[1:0]), $past(fifo_control_register[5:0])})
    else $error("threshold alias write wrong");
  rx_avail_a: assert property (rx_at_level |=> irq_status[IRQ_RX_AVAIL])
    else $error("data available event missed");
  dma_mode1_a: assert property (dma_mode && rx_at_level |=> !rx_dma_req_n_o)
    else $error("receive request not asserted at threshold");
  trig_top_a: assert property (q_enable && fifo_control_register[7:6] == 2'h3 |-> rx_level == CW'(DEPTH - 2))
    else $error("threshold code three misdecoded");
  dma_mode0_a: assert property (!dma_mode && rx_count == '0 |=> rx_dma_req_n_o)
    else $error("mode 0 request while empty");
  rts_gate_a: assert property (afc_on && rx_at_level |=> rts_n_o)
    else $error("request-to-send not dropped at threshold");
  alias_zero_a: assert property (alias_read_s |-> answer_zero_top_s)
    else $error("reserved alias bits not zero");

endmodule : uart_fifo_shadow_controls

//--- verification/uart_fifo_shadow_controls_bench.sv
// Self-checking bench for the serial port queue control aliases
`timescale 1ns/1ns
module uart_fifo_shadow_controls_bench
  import uart_shadow_pkg::*;
;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int D = 16;
  logic clk;
  logic rst;
  logic cyc;
  logic stb;
  logic we;
  logic [31:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic [CHAR_W-1:0] rx_data;
  logic rx_valid;
  logic [CHAR_W-1:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic rx_dma_n;
  logic tx_dma_n;
  logic rts_n;
  int n_fail;
  int n_checks;

  uart_fifo_shadow_controls #(.DEPTH(D)) uut (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .irq_o(irq),
    .rx_data_i(rx_data), .rx_valid_i(rx_valid), .tx_data_o(tx_data),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .rx_dma_req_n_o(rx_dma_n),
    .tx_dma_req_n_o(tx_dma_n), .rts_n_o(rts_n)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Waits on ack without assuming the latency, bounded by a count
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 100);
    q = rdat;
    if (k >= 100) begin
      n_fail++;
      $display("BAD ack wait expected ack seen none");
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask : rdc

  task automatic push(input logic [7:0] c);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= c;
    @(posedge clk);
    rx_valid <= 1'b0;
  endtask : push

  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle

  function automatic int lvl(input int code);
    case (code)
      0: return 1;
      1: return D / 4;
      2: return D / 2;
      default: return D - 2;
    endcase
  endfunction : lvl

  // ------------------------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Whole run needs a few hundred cycles; generous margin
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end

  initial begin
    n_fail = 0;
    n_checks = 0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 32'h0;
    sel = 4'h0;
    wdat = 32'h0;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // reset values, disabled queues hold one char
    rdc(ADR_QUEUE_ENABLE_ALIAS, 32'h0, "enable alias reset");
    rdc(ADR_RX_THRESHOLD_ALIAS, 32'h0, "threshold alias reset");
    rdc(32'h5000_1080, 32'h0, "unmapped read");
    for (int i = 0; i < 3; i++) push(8'h10 + 8'(i));
    rdc(ADR_LEVELS, 32'h1, "rx count disabled");
    // enable alias and queue reset on fall
    wr(ADR_QUEUE_ENABLE_ALIAS, 32'h0000_ffff);
    rdc(ADR_QUEUE_ENABLE_ALIAS, 32'h1, "enable alias bits");
    for (int i = 0; i < 3; i++) push(8'h20 + 8'(i));
    rdc(ADR_LEVELS, 32'h4, "rx count enabled");
    wr(ADR_DATA, 32'h5a);
    wr(ADR_QUEUE_ENABLE_ALIAS, 32'h0);
    rdc(ADR_LEVELS, 32'h0, "levels after disable");
    wr(ADR_FCR, 32'h89);
    rdc(ADR_RX_THRESHOLD_ALIAS, 32'h2, "threshold from control");
    rdc(ADR_QUEUE_ENABLE_ALIAS, 32'h1, "enable from control");
    wr(ADR_RX_THRESHOLD_ALIAS, 32'h0000_fffd);
    rdc(ADR_RX_THRESHOLD_ALIAS, 32'h1, "threshold alias bits");
    rdc(ADR_QUEUE_ENABLE_ALIAS, 32'h1, "enable kept");
    wr(ADR_QUEUE_ENABLE_ALIAS, 32'h1);
    rdc(ADR_RX_THRESHOLD_ALIAS, 32'h1, "threshold kept");
    // every threshold code, DMA mode 1 kept by alias write
    wr(ADR_IRQ_MASK, 32'h1);
    for (int c = 0; c < 4; c++) begin
      wr(ADR_FCR, 32'h0f);
      wr(ADR_RX_THRESHOLD_ALIAS, 32'(c));
      wr(ADR_IRQ_STATUS, 32'h7);
      for (int i = 1; i < lvl(c); i++) push(8'(i));
      settle();
      check("irq below threshold", 32'(irq), 32'h0);
      check("rx dma below threshold", 32'(rx_dma_n), 32'h1);
      push(8'hc3);
      settle();
      check("irq at threshold", 32'(irq), 32'h1);
      check("rx dma at threshold", 32'(rx_dma_n), 32'h0);
      rdc(ADR_LEVELS, 32'(lvl(c)), "rx count at threshold");
    end
    // Mask hides a pending status bit
    wr(ADR_IRQ_MASK, 32'h0);
    settle();
    check("irq masked", 32'(irq), 32'h0);
    // mode 0 requests and flow control at quarter threshold
    wr(ADR_FCR, 32'h47);
    wr(ADR_CTRL, 32'h3);
    settle();
    check("rts empty", 32'(rts_n), 32'h0);
    check("tx dma mode 0", 32'(tx_dma_n), 32'h0);
    for (int i = 1; i < lvl(1); i++) push(8'h30 + 8'(i));
    settle();
    check("rts below", 32'(rts_n), 32'h0);
    check("rx dma mode 0", 32'(rx_dma_n), 32'h0);
    push(8'h3f);
    settle();
    check("rts at threshold", 32'(rts_n), 32'h1);
    rdc(ADR_DATA, 32'h31, "first char out");
    settle();
    check("rts after pop", 32'(rts_n), 32'h0);
    // transmit queue in use while enabled
    tx_ready <= 1'b1;
    wr(ADR_DATA, 32'ha5);
    for (int k = 0; k < 20 && tx_valid !== 1'b1; k++) @(posedge clk);
    check("tx char", 32'(tx_data), 32'ha5);
    check("tx valid", 32'(tx_valid), 32'h1);
    @(posedge clk);
    check("tx valid after ready", 32'(tx_valid), 32'h0);
    // mode 1 transmit request, full queue, status readback
    tx_ready <= 1'b0;
    wr(ADR_FCR, 32'h5f);
    settle();
    check("tx dma mode 1 empty", 32'(tx_dma_n), 32'h0);
    // One char parks on the output, sixteen fill the queue, the last is dropped
    for (int i = 0; i < D + 2; i++) wr(ADR_DATA, 32'(i));
    settle();
    check("tx dma mode 1 full", 32'(tx_dma_n), 32'h1);
    rdc(ADR_LEVELS, 32'h0000_1000, "tx count full");
    wr(ADR_IRQ_STATUS, 32'h7);
    rdc(ADR_IRQ_STATUS, 32'h0, "status cleared");
    for (int i = 0; i < lvl(1); i++) push(8'h40 + 8'(i));
    rdc(ADR_IRQ_STATUS, 32'h1, "status at threshold");
    summarize();
  end
endmodule : uart_fifo_shadow_controls_bench
